// ===== pkg/crt_pkg.sv
// Purpose: Shared constants for the camera reset and trigger control block
// Assumes: 250 MHz system clock, control bits arrive as plain ports
// Notes: Times are kept in their own unit; cycle counts derive from them
package crt_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int SETTLE_MS = 100;
    localparam int SETTLE_CYCLES = SETTLE_MS * 1000 * CLK_MHZ;
    localparam int RESET_HOLD_US = 10;
    localparam int RESET_HOLD_CYCLES = RESET_HOLD_US * CLK_MHZ;
    localparam int CNT_W = 32;

    // ------------------------------------------------------------
    // Control word layout and window limits
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFSET = 8'h98;
    localparam int CTRL_AUTO_RST_BIT = 1;
    localparam int CTRL_HOLD_BIT = 2;
    localparam int CTRL_MOD_RST_BIT = 8;
    localparam int MAX_WIN_GLOBAL = 8;
    localparam int MAX_WIN_ROLLING = 1;
    localparam int COORD_W = 11;
    localparam int ADDR_W = 7;
    localparam logic [ADDR_W-1:0] I2C_ADDR_RESET = 7'h48;

    // ------------------------------------------------------------
    // Status function select codes
    // ------------------------------------------------------------
    localparam logic [2:0] MON_LOW = 3'h0;
    localparam logic [2:0] MON_INTEG = 3'h1;
    localparam logic [2:0] MON_ROT = 3'h2;
    localparam logic [2:0] MON_BLACK = 3'h3;
    localparam logic [2:0] MON_FIRST = 3'h4;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CRT_POWERUP = 3'b000,
        CRT_RUN = 3'b001,
        CRT_SENS_OFF = 3'b010,
        CRT_SENS_SETTLE = 3'b011,
        CRT_HOLD = 3'b100,
        CRT_MOD_OFF = 3'b101
    } crt_state_e;

endpackage : crt_pkg

// ===== rtl/crt_window_match.sv
// Purpose: Tests whether one pixel falls inside one readout window
// Assumes: Bounds are inclusive, pixel coordinates synchronous
// Notes: Instantiated once per window by the top module
module crt_window_match
    import crt_pkg::*;
(
    input wire logic [crt_pkg::COORD_W-1:0] pixX,
    input wire logic [crt_pkg::COORD_W-1:0] pixY,
    input wire logic [crt_pkg::COORD_W-1:0] winX0,
    input wire logic [crt_pkg::COORD_W-1:0] winX1,
    input wire logic [crt_pkg::COORD_W-1:0] winY0,
    input wire logic [crt_pkg::COORD_W-1:0] winY1,
    input wire logic enable,
    output logic hit
);
    // Inclusive rectangle test
    assign hit = enable && (pixX >= winX0) && (pixX <= winX1)
                 && (pixY >= winY0) && (pixY <= winY1);
endmodule : crt_window_match

// ===== rtl/camera_reset_trigger_control.sv
// Purpose: Sensor and module reset sequencing, exposure trigger, window mask, monitor
// Assumes: Sensor timing strobes are synchronous inputs; host keeps its waits
// Notes: Long settle count is a parameter so simulation can shorten it
//
// Overview of operation
// (R1) Global shutter allows up to eight windows
// (R2) Rolling shutter allows exactly one window
// (R3) Pixels leave in sensor order, only masked
// (R4) Master mode: rising trigger, register-timed integration
// (R5) Slave mode: trigger pulse width sets integration
// (R6) Trigger source avoids frame overhead interval
// (R7) Monitor carries source a or b by strap
// (R8) Integration function: high whole integration period
// (R9) Row overhead function: high during row overhead
// (R10) Black line function: high during black lines
// (R11) First line function: high only first line
// (R12) Power-up reset cycle, then host waits
// (R13) Auto sensor reset bit self clears
// (R14) Hold bit keeps sensor reset and unpowered
// (R15) Clearing hold restores power, releases reset
// (R16) Every sensor reset restores sensor defaults
// (R17) Host avoids sensor access during reset
// (R18) Module registers stay reachable during sensor reset
// (R19) Module reset resets all, self clears
// (R20) New bus address applies after module reset
// (R21) Auto reset is control bit 1
// (R22) Hold is control bit 2
// (R23) Module reset is control bit 8
// (R24) Auto cycle: off, wait, power on, release; the sequencer powers on and releases reset in the same cycle
// (R25) Active self-clearing bit reads as one
module camera_reset_trigger_control
    import crt_pkg::*;
#(
    parameter int SETTLE_COUNT = crt_pkg::SETTLE_CYCLES
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ctrlWrite,
    input wire logic [15:0] ctrlWdata,
    input wire logic [crt_pkg::ADDR_W-1:0] i2cAddrNew,
    input wire logic globalShutter,
    input wire logic slaveMode,
    input wire logic [15:0] integTime,
    input wire logic exposure_trigger_input,
    input wire logic monitorStrapB,
    input wire logic [2:0] monSelA,
    input wire logic [2:0] monSelB,
    input wire logic rowOverhead,
    input wire logic blackLine,
    input wire logic lineStart,
    input wire logic frameStart,
    input wire logic winWrite,
    input wire logic [2:0] winIndex,
    input wire logic [4*crt_pkg::COORD_W-1:0] winBounds,
    input wire logic winEnableIn,
    input wire logic pixValid,
    input wire logic [crt_pkg::COORD_W-1:0] pixX,
    input wire logic [crt_pkg::COORD_W-1:0] pixY,
    output logic [15:0] ctrlRdata,
    output logic sensorRst_n,
    output logic sensorPowerEn,
    output logic mcuRst_n,
    output logic moduleReady,
    output logic [crt_pkg::ADDR_W-1:0] i2cAddr,
    output logic integrating,
    output logic readoutStart,
    output logic pixKeep,
    output logic status_source_a,
    output logic status_source_b,
    output logic monitorOut
);
    import crt_pkg::*;

    // ------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------
    localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_COUNT - 1);
    localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(RESET_HOLD_CYCLES - 1);

    crt_state_e state;
    logic [CNT_W-1:0] timer;
    logic autoReq;
    logic holdBit;
    logic modReq;
    logic [ADDR_W-1:0] addrPending;
    logic sensorInReset;

    assign sensorInReset = (state == CRT_SENS_OFF) || (state == CRT_HOLD)
                           || (state == CRT_MOD_OFF) || (state == CRT_POWERUP);

    // Control bits; self-clearing bits drop only at cycle end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            autoReq <= 1'b0;
            holdBit <= 1'b0;
            modReq <= 1'b0;
        end else if (state == CRT_MOD_OFF && timer == HOLD_LAST) begin
            autoReq <= 1'b0; // R19
            holdBit <= 1'b0; // R19
            modReq <= 1'b0; // R19
        end else begin
            if (ctrlWrite && ctrlWdata[CTRL_AUTO_RST_BIT]) begin
                autoReq <= 1'b1; // R13 R21
            end else if (state == CRT_SENS_SETTLE && timer == SETTLE_LAST) begin
                autoReq <= 1'b0; // R13
            end
            if (ctrlWrite) begin
                holdBit <= ctrlWdata[CTRL_HOLD_BIT]; // R14 R22
            end
            if (ctrlWrite && ctrlWdata[CTRL_MOD_RST_BIT]) begin
                modReq <= 1'b1; // R19 R23
            end
        end
    end

    // Sequencer; module reset outranks hold, hold outranks auto reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= CRT_POWERUP;
            timer <= '0;
        end else begin
            case (state)
                CRT_POWERUP: begin
                    // Sensor stays off for the hold time, then settles
                    if (timer == HOLD_LAST) begin
                        state <= CRT_SENS_SETTLE; // R12
                        timer <= '0;
                    end else begin
                        timer <= timer + 1'b1;
                    end
                end
                CRT_RUN: begin
                    timer <= '0;
                    if (modReq) begin
                        state <= CRT_MOD_OFF;
                    end else if (holdBit) begin
                        state <= CRT_HOLD; // R14
                    end else if (autoReq) begin
                        state <= CRT_SENS_OFF; // R13
                    end
                end
                CRT_SENS_OFF: begin
                    // Power off and reset for the full settle time
                    if (modReq) begin
                        state <= CRT_MOD_OFF;
                        timer <= '0;
                    end else if (timer == SETTLE_LAST) begin
                        state <= CRT_SENS_SETTLE; // R24
                        timer <= '0;
                    end else begin
                        timer <= timer + 1'b1;
                    end
                end
                CRT_SENS_SETTLE: begin
                    // Powered and released; host still waits out this period
                    if (modReq) begin
                        state <= CRT_MOD_OFF;
                        timer <= '0;
                    end else if (timer == SETTLE_LAST) begin
                        state <= CRT_RUN; // R15 R12
                        timer <= '0;
                    end else begin
                        timer <= timer + 1'b1;
                    end
                end
                CRT_HOLD: begin
                    timer <= '0;
                    if (modReq) begin
                        state <= CRT_MOD_OFF;
                    end else if (!holdBit) begin
                        state <= CRT_SENS_SETTLE; // R15
                    end
                end
                CRT_MOD_OFF: begin
                    if (timer == HOLD_LAST) begin
                        state <= CRT_SENS_SETTLE; // R19
                        timer <= '0;
                    end else begin
                        timer <= timer + 1'b1;
                    end
                end
                default: begin
                    state <= CRT_POWERUP;
                    timer <= '0;
                end
            endcase
        end
    end

    // Sensor pins, registered; reset drop also clears sensor registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sensorRst_n <= 1'b0;
            sensorPowerEn <= 1'b0;
            mcuRst_n <= 1'b0;
            moduleReady <= 1'b0;
        end else begin
            sensorRst_n <= !sensorInReset; // R16 R24
            sensorPowerEn <= !sensorInReset; // R14 R15
            mcuRst_n <= (state != CRT_MOD_OFF); // R19
            moduleReady <= (state == CRT_RUN); // R12 R17
        end
    end

    // Readback served in every state, so polling works during reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrlRdata <= '0;
        end else begin
            ctrlRdata <= '0; // R18
            ctrlRdata[CTRL_AUTO_RST_BIT] <= autoReq || state == CRT_SENS_OFF; // R25
            ctrlRdata[CTRL_HOLD_BIT] <= holdBit;
            ctrlRdata[CTRL_MOD_RST_BIT] <= modReq; // R25
        end
    end

    // Bus address: pending value adopted only by a module reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            addrPending <= I2C_ADDR_RESET;
            i2cAddr <= I2C_ADDR_RESET;
        end else begin
            addrPending <= i2cAddrNew;
            if (state == CRT_MOD_OFF && timer == HOLD_LAST) begin
                i2cAddr <= addrPending; // R20
            end
        end
    end

    // ------------------------------------------------------------
    // Exposure trigger
    // ------------------------------------------------------------
    logic trigPrev;
    logic [15:0] integCount;
    logic trigRise;
    logic trigFall;

    assign trigRise = exposure_trigger_input && !trigPrev;
    assign trigFall = !exposure_trigger_input && trigPrev;

    // Integration window; triggers during sensor reset are ignored
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            trigPrev <= 1'b0;
            integrating <= 1'b0;
            readoutStart <= 1'b0;
            integCount <= '0;
        end else begin
            trigPrev <= exposure_trigger_input; // R6 relies on clean source
            readoutStart <= 1'b0;
            if (sensorInReset) begin
                integrating <= 1'b0;
            end else if (!integrating) begin
                if (trigRise) begin
                    integrating <= 1'b1; // R4 R5
                    integCount <= integTime;
                end
            end else if (slaveMode) begin
                if (trigFall) begin
                    integrating <= 1'b0; // R5
                    readoutStart <= 1'b1;
                end
            end else if (integCount <= 16'h0001) begin
                integrating <= 1'b0; // R4
                readoutStart <= 1'b1;
            end else begin
                integCount <= integCount - 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // Readout windows
    // ------------------------------------------------------------
    logic [COORD_W-1:0] winX0 [MAX_WIN_GLOBAL];
    logic [COORD_W-1:0] winX1 [MAX_WIN_GLOBAL];
    logic [COORD_W-1:0] winY0 [MAX_WIN_GLOBAL];
    logic [COORD_W-1:0] winY1 [MAX_WIN_GLOBAL];
    logic [MAX_WIN_GLOBAL-1:0] winEn;
    logic [MAX_WIN_GLOBAL-1:0] winLive;
    logic [MAX_WIN_GLOBAL-1:0] winHit;

    // Window store
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            winEn <= '0;
            for (int i = 0; i < MAX_WIN_GLOBAL; i++) begin
                winX0[i] <= '0;
                winX1[i] <= '0;
                winY0[i] <= '0;
                winY1[i] <= '0;
            end
        end else if (state == CRT_MOD_OFF) begin
            winEn <= '0;
        end else if (winWrite) begin
            winEn[winIndex] <= winEnableIn; // R1
            winX0[winIndex] <= winBounds[0*COORD_W +: COORD_W];
            winX1[winIndex] <= winBounds[1*COORD_W +: COORD_W];
            winY0[winIndex] <= winBounds[2*COORD_W +: COORD_W];
            winY1[winIndex] <= winBounds[3*COORD_W +: COORD_W];
        end
    end

    // Rolling shutter masks all but window zero
    assign winLive = globalShutter ? winEn
                     : (winEn & MAX_WIN_GLOBAL'(MAX_WIN_ROLLING)); // R1 R2

    // One comparator per window
    genvar g;
    generate
        for (g = 0; g < MAX_WIN_GLOBAL; g++) begin : gWin
            crt_window_match uMatch (
                .pixX(pixX),
                .pixY(pixY),
                .winX0(winX0[g]),
                .winX1(winX1[g]),
                .winY0(winY0[g]),
                .winY1(winY1[g]),
                .enable(winLive[g]),
                .hit(winHit[g])
            );
        end
    endgenerate

    // Keep flag per pixel; stream order untouched, no reordering buffer
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pixKeep <= 1'b0;
        end else begin
            pixKeep <= pixValid && (|winHit); // R3
        end
    end

    // ------------------------------------------------------------
    // Status signals and monitor
    // ------------------------------------------------------------
    logic firstLine;

    // First line flag spans from frame start to the next line start
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            firstLine <= 1'b0;
        end else if (frameStart) begin
            firstLine <= 1'b1; // R11
        end else if (lineStart) begin
            firstLine <= 1'b0; // R11
        end
    end

    // Function mux; unsupported codes give constant low
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            status_source_a <= 1'b0;
            status_source_b <= 1'b0;
            monitorOut <= 1'b0;
        end else begin
            case (monSelA)
                MON_INTEG: status_source_a <= integrating; // R8
                MON_ROT: status_source_a <= rowOverhead; // R9
                MON_FIRST: status_source_a <= firstLine; // R11
                default: status_source_a <= 1'b0;
            endcase
            case (monSelB)
                MON_ROT: status_source_b <= rowOverhead; // R9
                MON_BLACK: status_source_b <= blackLine; // R10
                default: status_source_b <= 1'b0;
            endcase
            monitorOut <= monitorStrapB ? status_source_b : status_source_a; // R7
        end
    end

endmodule : camera_reset_trigger_control

// ===== verification/crt_checker.sv
// Purpose: Port assertions for reset, trigger and monitor
// Assumes: One clock domain, bound to the top module
// Notes: Helper counter times master integration
module crt_checker
    import crt_pkg::*;
#(
    parameter int SETTLE_COUNT = 20
)
(
    input logic clk,
    input logic arst_n,
    input logic ctrlWrite,
    input logic [15:0] ctrlWdata,
    input logic slaveMode,
    input logic [15:0] integTime,
    input logic exposure_trigger_input,
    input logic monitorStrapB,
    input logic [2:0] monSelA,
    input logic [2:0] monSelB,
    input logic rowOverhead,
    input logic blackLine,
    input logic [15:0] ctrlRdata,
    input logic sensorRst_n,
    input logic sensorPowerEn,
    input logic mcuRst_n,
    input logic moduleReady,
    input logic [crt_pkg::ADDR_W-1:0] i2cAddr,
    input logic integrating,
    input logic readoutStart,
    input logic status_source_a,
    input logic status_source_b,
    input logic monitorOut
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] integCnt;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // Cycles spent integrating, cleared while idle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            integCnt <= 16'h0000;
        end else begin
            integCnt <= integrating ? integCnt + 16'h0001 : 16'h0000;
        end
    end

    // Auto cycle: bit reads back, then sensor reset with supply off
    sequence autoWrite;
        ctrlWrite && ctrlWdata[1] && !ctrlWdata[2] && !ctrlWdata[8] && moduleReady;
    endsequence
    sequence sensorOff;
        !sensorRst_n && !sensorPowerEn;
    endsequence
    AST_AUTO_START: assert property (autoWrite |-> ##2 ctrlRdata[1] ##1 sensorOff)
        else $error("auto start");
    AST_AUTO_DONE: assert property ($fell(ctrlRdata[1]) && !$past(ctrlRdata[8])
        |-> ##[0:3] moduleReady)
        else $error("auto done");
    AST_HOLD_OFF: assert property (ctrlRdata[2] [*3] |-> sensorOff ##0 !moduleReady)
        else $error("hold off");
    AST_MOD_START: assert property (ctrlWrite && ctrlWdata[8] && moduleReady
        |-> ##[1:4] !mcuRst_n && !sensorRst_n)
        else $error("module start");
    AST_ADDR_HOLD: assert property (mcuRst_n && $past(mcuRst_n) && $past(mcuRst_n, 2)
        |-> $stable(i2cAddr))
        else $error("address hold");
    // Trigger start and end
    AST_TRIG_START: assert property ($rose(exposure_trigger_input) && !integrating
        && !readoutStart && moduleReady |=> integrating)
        else $error("trigger start");
    AST_READOUT: assert property (readoutStart |-> !integrating && $past(integrating))
        else $error("readout");
    AST_MASTER_LEN: assert property (readoutStart && !slaveMode |-> integCnt == integTime)
        else $error("master length");
    AST_SLAVE_END: assert property (slaveMode && integrating && $fell(exposure_trigger_input)
        |-> ##[0:2] readoutStart)
        else $error("slave end");
    // Monitor follows strap, sources follow their functions
    AST_MONITOR: assert property (1'b1 |=> monitorOut == ($past(monitorStrapB)
        ? $past(status_source_b) : $past(status_source_a)))
        else $error("monitor");
    AST_ROW_A: assert property (monSelA == MON_ROT |=> status_source_a == $past(rowOverhead))
        else $error("row a");
    AST_BLACK_B: assert property (monSelB == MON_BLACK |=> status_source_b == $past(blackLine))
        else $error("black b");
endmodule : crt_checker

bind camera_reset_trigger_control crt_checker #(.SETTLE_COUNT(SETTLE_COUNT)) u_checker (.*);

// ===== verification/crt_host_model.sv
// Purpose: Host side that writes the control word and keeps its waits
// Assumes: Writes launched at the falling edge
// Notes: Idle data is the inverse
module crt_host_model
(
    input logic clk,
    input logic moduleReady,
    output logic ctrlWrite,
    output logic [15:0] ctrlWdata
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        ctrlWrite = 1'b0;
        ctrlWdata = 16'hFFFF;
    end

    // One-cycle write strobe with its word
    task automatic write_word(input logic [15:0] w);
        @(negedge clk);
        ctrlWrite = 1'b1;
        ctrlWdata = w;
        @(negedge clk);
        ctrlWrite = 1'b0;
        ctrlWdata = ~w;
    endtask : write_word

    // No sensor access until the settle wait is over
    task automatic wait_ready(input int limit, output logic ok);
        ok = 1'b0;
        for (int i = 0; i < limit && !ok; i++) begin
            @(negedge clk);
            ok = moduleReady;
        end
    endtask : wait_ready
endmodule : crt_host_model

// ===== verification/testbench.sv
// Purpose: Self-checking bench for reset, trigger, windows and monitor
// Assumes: Settle count shortened to SC cycles
// Notes: Inputs change on the falling edge only
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import crt_pkg::*;
    localparam int SC = 20;
    logic clk, arst_n, ctrlWrite, globalShutter, slaveMode, exposure_trigger_input;
    logic monitorStrapB, rowOverhead, blackLine, lineStart, frameStart, winWrite, winEnableIn;
    logic pixValid, sensorRst_n, sensorPowerEn, mcuRst_n, moduleReady, integrating;
    logic readoutStart, pixKeep, status_source_a, status_source_b, monitorOut, ok;
    logic [15:0] ctrlWdata, integTime, ctrlRdata;
    logic [ADDR_W-1:0] i2cAddrNew, i2cAddr;
    logic [2:0] monSelA, monSelB, winIndex;
    logic [4*COORD_W-1:0] winBounds;
    logic [COORD_W-1:0] pixX, pixY;
    int bad_count = 0;
    int tests_run = 0;
    int n, r, a;

    camera_reset_trigger_control #(.SETTLE_COUNT(SC)) uut (.*);
    crt_host_model host (.clk, .moduleReady, .ctrlWrite, .ctrlWdata);

    // ----------------------------------------
    // Compare and report
    // ----------------------------------------
    task automatic chk_bit(input string nm, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit

    task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_word

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    // Window write; pixel keep seen a cycle on
    task automatic set_win(input logic [2:0] idx, input logic [43:0] b);
        winIndex = idx;
        winBounds = b;
        winWrite = 1'b1;
        @(negedge clk);
        winWrite = 1'b0;
    endtask : set_win

    task automatic pix(input logic [10:0] x, input logic [10:0] y, input logic e);
        pixX = x;
        pixY = y;
        pixValid = 1'b1;
        @(negedge clk);
        pixValid = 1'b0;
        chk_bit("pixKeep", e, pixKeep);
    endtask : pix

    // Pulse of hi cycles; master sees a refused rise
    task automatic trig(input logic slave, input int hi);
        slaveMode = slave;
        n = 0;
        r = 0;
        a = 0;
        exposure_trigger_input = 1'b1;
        for (int i = 1; i < 40; i++) begin
            @(negedge clk);
            exposure_trigger_input = (i < hi) || (!slave && (i == 4 || i == 5));
            n += int'(integrating);
            r += int'(readoutStart);
            a += int'(status_source_a);
        end
        chk_word("readouts", 16'h0001, r[15:0]);
        chk_word("integMon", n[15:0], a[15:0]);
    endtask : trig

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk_word("addrRst", 16'(I2C_ADDR_RESET), 16'(i2cAddr));
        chk_bit("powerRst", 1'b0, sensorPowerEn);
        arst_n = 1'b1;
        host.wait_ready(RESET_HOLD_CYCLES + SC + 50, ok);
        chk_bit("upReady", 1'b1, ok && sensorPowerEn && sensorRst_n && mcuRst_n);
    endtask : t_reset

    task automatic t_auto();
        host.write_word(16'h0002);
        repeat (3) @(negedge clk);
        chk_word("autoBit", 16'h0002, ctrlRdata);
        chk_bit("autoOff", 1'b0, sensorPowerEn || sensorRst_n);
        n = 0;
        while (!sensorPowerEn && n < 1000) begin
            @(negedge clk);
            n++;
        end
        chk_bit("offLen", 1'b1, n >= SC - 2 && n <= SC + 2);
        host.wait_ready(SC + 20, ok);
        chk_bit("autoReady", 1'b1, ok);
        chk_word("autoClr", 16'h0000, ctrlRdata);
    endtask : t_auto

    task automatic t_hold();
        host.write_word(16'h0004);
        repeat (50) @(negedge clk);
        chk_word("holdBit", 16'h0004, ctrlRdata);
        chk_bit("holdOff", 1'b0, sensorPowerEn || sensorRst_n || moduleReady);
        host.write_word(16'h0000);
        host.wait_ready(SC + 20, ok);
        chk_bit("holdExit", 1'b1, ok && sensorPowerEn && sensorRst_n);
    endtask : t_hold

    task automatic t_trigger();
        monSelA = MON_INTEG;
        trig(1'b0, 2);
        chk_word("masterLen", integTime, n[15:0]);
        trig(1'b1, 10);
        chk_bit("slaveLen", 1'b1, n >= 9 && n <= 11);
    endtask : t_trigger

    task automatic t_monitor();
        for (int k = 0; k < 3; k++) begin
            monitorStrapB = (k == 2);
            monSelA = (k == 0) ? MON_ROT : MON_FIRST;
            for (int v = 1; v >= 0; v--) begin
                rowOverhead = (k == 0) && v;
                blackLine = (k == 2) && v;
                frameStart = (k == 1) && v;
                lineStart = (k == 1) && !v;
                @(negedge clk);
                frameStart = 1'b0;
                lineStart = 1'b0;
                repeat (2) @(negedge clk);
                chk_bit("monitorOut", v[0], monitorOut);
            end
        end
    endtask : t_monitor

    task automatic t_windows();
        set_win(3'h0, {11'h003, 11'h000, 11'h003, 11'h000});
        set_win(3'h7, {11'h000, 11'h000, 11'h00C, 11'h00A});
        pix(11'h00B, 11'h000, 1'b1);
        pix(11'h00D, 11'h000, 1'b0);
        pix(11'h002, 11'h002, 1'b1);
        globalShutter = 1'b0;
        pix(11'h00B, 11'h000, 1'b0);
        pix(11'h002, 11'h002, 1'b1);
    endtask : t_windows

    task automatic t_modrst();
        i2cAddrNew = 7'h21;
        repeat (4) @(negedge clk);
        chk_word("addrEarly", 16'(I2C_ADDR_RESET), 16'(i2cAddr));
        host.write_word(16'h0100);
        repeat (3) @(negedge clk);
        chk_bit("mcuRst", 1'b0, mcuRst_n);
        chk_bit("modBit", 1'b1, ctrlRdata[8]);
        host.wait_ready(RESET_HOLD_CYCLES + SC + 50, ok);
        chk_bit("modReady", 1'b1, ok);
        chk_word("addrNew", 16'h0021, 16'(i2cAddr));
        chk_word("modClr", 16'h0000, ctrlRdata);
        pix(11'h002, 11'h002, 1'b0);
    endtask : t_modrst

    // Clock, 4 ns period
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Main sequence
    initial begin
        {arst_n, globalShutter, slaveMode, exposure_trigger_input, monitorStrapB} = 5'b01000;
        {rowOverhead, blackLine, lineStart, frameStart, winWrite, pixValid} = 6'h00;
        winEnableIn = 1'b1;
        integTime = 16'h0008;
        i2cAddrNew = I2C_ADDR_RESET;
        {monSelA, monSelB, winIndex} = {MON_LOW, MON_BLACK, 3'h0};
        winBounds = '0;
        {pixX, pixY} = '0;
        repeat (8) @(negedge clk);
        t_reset();
        t_auto();
        t_hold();
        t_trigger();
        t_monitor();
        t_windows();
        t_modrst();
        print_verdict();
    end

    // Watchdog, far past the run
    initial begin
        #200000;
        bad_count++;
        print_verdict();
    end
endmodule : testbench
